// [rx_regs_pkg.sv]
// constants, field positions and carrier types of the receiver register bank
// assumes one 125 MHz system clock and a byte-wide two-wire serial host port
//
// Contract
// (R01) enable byte 0x03 bit 7 routes thermistor b overtemperature to the interrupt pin
// (R02) enable byte 0x03 bit 6 routes thermistor a overtemperature to the interrupt pin
// (R03) enable byte 0x03 bit 5 routes die shutdown condition to the interrupt pin
// (R04) enable byte 0x03 bit 2 routes charge-complete input to the interrupt pin
// (R05) enable byte 0x03 bit 0 routes disable pin high to the interrupt pin
// (R06) enable byte 0x02 bit 4 routes thermal regulation; other bits reserved, default one
// (R07) shut down when die temperature reaches threshold plus hysteresis
// (R08) below threshold no shutdown, though an end-of-power packet may still go
// (R09) between threshold minus ten and threshold, request end-of-power packet for die temperature
// (R10) more than twenty below threshold, no die-temperature end-of-power packet
// (R11) byte 0x08 bits 7:6 pick off, 130, 140 or 150 degrees; default code one
// (R12) byte 0x08 bit 5 picks hysteresis ten or twenty degrees, default twenty
// (R13) byte 0x33 bit 7 picks setpoint source: zero resistor pin, one register code
// (R14) five-bit voltage code decodes to the fixed table; codes one to five reserved
// (R15) byte 0x69 reads the thermistor a conversion
// (R16) byte 0x6b reads the thermistor b conversion
// (R17) twelve-bit switching period count in 0x7e bits 3:0 and 0x7f
// (R18) masked flag set only when condition present and enable is one; drives interrupt
// (R19) die-temperature end-of-power packet carries parameter code 0x02
// (R20) upper then lower period byte reads come from one measurement

package rx_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_IRQ_EN_HIGH = 8'h02;
  localparam logic [7:0] ADDR_IRQ_EN_LOW = 8'h03;
  localparam logic [7:0] ADDR_DIE_CFG = 8'h08;
  localparam logic [7:0] ADDR_VOUT_CTRL = 8'h33;
  localparam logic [7:0] ADDR_TS_A = 8'h69;
  localparam logic [7:0] ADDR_TS_B = 8'h6b;
  localparam logic [7:0] ADDR_PERIOD_UPPER = 8'h7e;
  localparam logic [7:0] ADDR_PERIOD_LOWER = 8'h7f;

  // reset values
  localparam logic [7:0] IRQ_EN_HIGH_RST = 8'hff;
  localparam logic [7:0] IRQ_EN_LOW_RST = 8'hff;
  localparam logic [7:0] DIE_CFG_RST = 8'h60;
  localparam logic [7:0] VOUT_CTRL_RST = 8'h00;

  // field positions
  localparam int EN_TS_B_BIT = 7;
  localparam int EN_TS_A_BIT = 6;
  localparam int EN_DIE_BIT = 5;
  localparam int EN_CHG_BIT = 2;
  localparam int EN_DIS_BIT = 0;
  localparam int EN_THERM_BIT = 4;
  localparam int DIE_THR_MSB = 7;
  localparam int DIE_THR_LSB = 6;
  localparam int DIE_HYS_BIT = 5;
  localparam int VOUT_SEL_BIT = 7;
  localparam int VOUT_CODE_MSB = 4;
  localparam int PERIOD_UPPER_MSB = 3;

  ////////////////////////////////////////////////////////////////////////////
  // die temperature figures in degrees
  localparam logic [8:0] T_SHDN_130 = 9'h082;
  localparam logic [8:0] T_SHDN_140 = 9'h08c;
  localparam logic [8:0] T_SHDN_150 = 9'h096;
  localparam logic [8:0] T_HYS_SMALL = 9'h00a;
  localparam logic [8:0] T_HYS_LARGE = 9'h014;
  localparam logic [8:0] T_EPT_BAND = 9'h00a;
  localparam logic [8:0] T_EPT_QUIET = 9'h014;

  // end-of-power packet parameter codes
  localparam logic [7:0] EPT_DIE_CODE = 8'h02;
  localparam logic [7:0] EPT_NONE = 8'hff;

  // output voltage setpoints in millivolts
  localparam logic [12:0] VOUT_4V50 = 13'h1194;
  localparam logic [12:0] VOUT_4V75 = 13'h128e;
  localparam logic [12:0] VOUT_5V00 = 13'h1388;
  localparam logic [12:0] VOUT_5V25 = 13'h1482;
  localparam logic [12:0] VOUT_5V50 = 13'h157c;
  localparam logic [12:0] VOUT_5V75 = 13'h1676;
  localparam logic [12:0] VOUT_6V00 = 13'h1770;

  ////////////////////////////////////////////////////////////////////////////
  // fault conditions, one bit per interrupt source
  typedef struct packed {
    logic ts_b_hot;
    logic ts_a_hot;
    logic die_hot;
    logic charge_done;
    logic disable_high;
    logic thermal_reg;
  } fault_t;

  // one register access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } bus_req_t;

  // voltage code table; reserved codes fall back to 5.00 V
  function automatic logic [12:0] vout_decode(input logic [4:0] code);
    logic [12:0] mv;
    mv = VOUT_5V00;
    case (code)
      5'h06: mv = VOUT_4V50;
      5'h07, 5'h08: mv = VOUT_4V75;
      5'h09, 5'h0a: mv = VOUT_5V25;
      5'h0b, 5'h0c: mv = VOUT_5V50;
      5'h0d, 5'h0e: mv = VOUT_5V75;
      5'h0f, 5'h10, 5'h11: mv = VOUT_6V00;
      default: mv = VOUT_5V00;
    endcase
    return mv;
  endfunction

  function automatic logic vout_code_valid(input logic [4:0] code);
    return (code == 5'h00) || ((code >= 5'h06) && (code <= 5'h11));
  endfunction

endpackage

// [serial_reg_port.sv]
// two-wire serial target: address match, register pointer, byte reads and writes
// assumes scl and sda already synchronous to sys_clk; sda released means high
`timescale 1ns/10ps

module serial_reg_port #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary default target address
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // serial clock level
  input wire logic sda_i, // serial data level
  output logic sda_oe, // high pulls sda low
  output rx_regs_pkg::bus_req_t req, // one-cycle access strobe
  input wire logic [7:0] rdata // read data for req.addr, same cycle
);

  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WRITE, WRITE_ACK, READ, READ_ACK} state_t;

  state_t state_reg, state_next;
  logic scl_reg, sda_reg;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] rx_reg, rx_next, tx_reg, tx_next, ptr_reg, ptr_next;
  logic rw_reg, rw_next, first_reg, first_next, ack_reg, ack_next, oe_next;
  rx_regs_pkg::bus_req_t req_next;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  // bus events from the previous and present pin levels
  assign start_ev = scl_reg && scl_i && sda_reg && !sda_i;
  assign stop_ev = scl_reg && scl_i && !sda_reg && sda_i;
  assign scl_rise = !scl_reg && scl_i;
  assign scl_fall = scl_reg && !scl_i;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine; the pointer survives a repeated start so write-pointer-then-read works
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    ack_next = ack_reg;
    oe_next = sda_oe;
    req_next = '0;
    if (start_ev) begin
      state_next = ADDR;
      cnt_next = 4'h0;
      first_next = 1'b1;
      oe_next = 1'b0;
    end else if (stop_ev) begin
      state_next = IDLE;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      if (state_reg == ADDR || state_reg == WRITE) begin
        rx_next = {rx_reg[6:0], sda_i};
        cnt_next = cnt_reg + 4'h1;
      end else if (state_reg == READ) begin
        cnt_next = cnt_reg + 4'h1;
      end else if (state_reg == READ_ACK) begin
        ack_next = !sda_i;
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        IDLE: ;
        ADDR: if (cnt_reg == 4'h8) begin
          if (rx_reg[7:1] == DEV_ADDR) begin
            oe_next = 1'b1;
            rw_next = rx_reg[0];
            state_next = ADDR_ACK;
          end else begin
            state_next = IDLE;
          end
        end
        WRITE: if (cnt_reg == 4'h8) begin
          if (first_reg) begin
            ptr_next = rx_reg;
          end else begin
            req_next.wr = 1'b1;
            req_next.addr = ptr_reg;
            req_next.data = rx_reg;
            ptr_next = ptr_reg + 8'h01;
          end
          first_next = 1'b0;
          oe_next = 1'b1;
          state_next = WRITE_ACK;
        end
        WRITE_ACK: begin
          oe_next = 1'b0;
          cnt_next = 4'h0;
          state_next = WRITE;
        end
        ADDR_ACK, READ_ACK: begin
          cnt_next = 4'h0;
          if (state_reg == ADDR_ACK && !rw_reg) begin
            oe_next = 1'b0;
            state_next = WRITE;
          end else if (state_reg == ADDR_ACK || ack_reg) begin
            // ask for a byte; the bank answers while the strobe stands, one cycle on
            req_next.rd = 1'b1;
            req_next.addr = ptr_reg;
            oe_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
            state_next = READ;
          end else begin
            oe_next = 1'b0;
            state_next = IDLE;
          end
        end
        READ: begin
          if (cnt_reg == 4'h8) begin
            oe_next = 1'b0;
            state_next = READ_ACK;
          end else begin
            oe_next = !tx_reg[3'h7 - cnt_reg[2:0]];
          end
        end
      endcase
    end
    // read data belongs to the registered strobe's address, so load it only now
    if (req.rd) begin
      tx_next = rdata;
      oe_next = !rdata[7];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_oe <= 1'b0;
      req <= '0;
    end else begin
      state_reg <= state_next;
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      ack_reg <= ack_next;
      sda_oe <= oe_next;
      req <= req_next;
    end
  end

endmodule

// [rx_irq_thermal_vout_regs.sv]
// receiver register bank: interrupt routing, die thermal limits, output voltage select,
// thermistor and switching period readback
// assumes all analog measurements arrive as synchronous digital words on sys_clk
`timescale 1ns/10ps

module rx_irq_thermal_vout_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary default serial target address
) (
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe, // high while pulling sda low
  input wire logic int_i, // interrupt pin level, for observation only
  output logic int_o, // interrupt drive value, always low
  output logic int_oe, // high while pulling the interrupt pin low
  input wire logic ts_a_hot, // thermistor a above its limit
  input wire logic ts_b_hot, // thermistor b above its limit
  input wire logic thermal_reg_active, // thermal regulation loop active
  input wire logic charge_done, // charge-complete pin asserted
  input wire logic disable_pin, // disable pin driven high
  input wire logic [7:0] die_temp_c, // die temperature in degrees
  input wire logic [7:0] ts_a_adc, // thermistor a conversion
  input wire logic [7:0] ts_b_adc, // thermistor b conversion
  input wire logic [11:0] period_count, // switching period in 3.125 ns steps
  input wire logic [12:0] pin_vout_mv, // setpoint from the resistor pin, mV
  output logic die_shutdown, // die over-temperature shutdown
  output logic ept_request, // die-temperature end-of-power request
  output logic [7:0] ept_code, // packet parameter code
  output logic [12:0] vout_target_mv, // selected output voltage, mV
  output logic vout_code_ok, // register code is a defined entry
  output logic vout_use_reg // setpoint taken from the register code
);

  rx_regs_pkg::bus_req_t req;
  logic [7:0] rdata;
  logic [7:0] en_hi_reg, en_hi_next, en_lo_reg, en_lo_next;
  logic [7:0] die_cfg_reg, die_cfg_next, vout_ctrl_reg, vout_ctrl_next;
  logic [7:0] ts_a_reg, ts_b_reg, lower_shadow_reg, lower_shadow_next;
  rx_regs_pkg::fault_t cond, route, masked_reg, masked_next;
  logic int_oe_next, shdn_next, ept_next;
  logic [8:0] temp9, thr, hys;
  logic thr_on;
  logic [12:0] vout_next;
  logic vout_ok_next;

  assign sda_o = 1'b0;
  assign int_o = 1'b0;

  serial_reg_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe(sda_oe),
    .req(req),
    .rdata(rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped bytes and the reserved bits 6:5 of 0x33 read zero; enable bytes read back as written
  // the port's strobe is registered, so req.addr already names the byte being read
  always_comb begin
    rdata = 8'h00;
    case (req.addr)
      rx_regs_pkg::ADDR_IRQ_EN_HIGH: rdata = en_hi_reg;
      rx_regs_pkg::ADDR_IRQ_EN_LOW: rdata = en_lo_reg;
      rx_regs_pkg::ADDR_DIE_CFG: rdata = die_cfg_reg;
      rx_regs_pkg::ADDR_VOUT_CTRL: rdata = {vout_ctrl_reg[7], 2'b00, vout_ctrl_reg[4:0]};
      rx_regs_pkg::ADDR_TS_A: rdata = ts_a_reg; // R15
      rx_regs_pkg::ADDR_TS_B: rdata = ts_b_reg; // R16
      rx_regs_pkg::ADDR_PERIOD_UPPER: rdata = {4'h0, period_count[11:8]}; // R17
      rx_regs_pkg::ADDR_PERIOD_LOWER: rdata = lower_shadow_reg; // R17
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers and the period shadow
  always_comb begin
    en_hi_next = en_hi_reg;
    en_lo_next = en_lo_reg;
    die_cfg_next = die_cfg_reg;
    vout_ctrl_next = vout_ctrl_reg;
    lower_shadow_next = lower_shadow_reg;
    if (req.wr) begin
      case (req.addr)
        rx_regs_pkg::ADDR_IRQ_EN_HIGH: en_hi_next = req.data; // R06
        rx_regs_pkg::ADDR_IRQ_EN_LOW: en_lo_next = req.data;
        rx_regs_pkg::ADDR_DIE_CFG: die_cfg_next = req.data; // R11 R12
        rx_regs_pkg::ADDR_VOUT_CTRL: vout_ctrl_next = {req.data[7], 2'b00, req.data[4:0]};
        default: ;
      endcase
    end
    // reading the upper byte freezes the lower byte of the same sample
    if (req.rd && req.addr == rx_regs_pkg::ADDR_PERIOD_UPPER) begin
      lower_shadow_next = period_count[7:0]; // R20
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_hi_reg <= rx_regs_pkg::IRQ_EN_HIGH_RST;
      en_lo_reg <= rx_regs_pkg::IRQ_EN_LOW_RST;
      die_cfg_reg <= rx_regs_pkg::DIE_CFG_RST;
      vout_ctrl_reg <= rx_regs_pkg::VOUT_CTRL_RST;
      lower_shadow_reg <= 8'h00;
    end else begin
      en_hi_reg <= en_hi_next;
      en_lo_reg <= en_lo_next;
      die_cfg_reg <= die_cfg_next;
      vout_ctrl_reg <= vout_ctrl_next;
      lower_shadow_reg <= lower_shadow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // die thermal limits: shutdown latches at threshold plus hysteresis and releases below
  // threshold; the packet request holds between the quiet and band edges so it cannot chatter
  assign temp9 = {1'b0, die_temp_c};
  assign hys = die_cfg_reg[rx_regs_pkg::DIE_HYS_BIT] ? rx_regs_pkg::T_HYS_LARGE : rx_regs_pkg::T_HYS_SMALL; // R12

  always_comb begin
    thr_on = 1'b1;
    unique case (die_cfg_reg[rx_regs_pkg::DIE_THR_MSB:rx_regs_pkg::DIE_THR_LSB]) // R11
      2'h0: begin
        thr = 9'h000;
        thr_on = 1'b0;
      end
      2'h1: thr = rx_regs_pkg::T_SHDN_130;
      2'h2: thr = rx_regs_pkg::T_SHDN_140;
      2'h3: thr = rx_regs_pkg::T_SHDN_150;
    endcase
    shdn_next = die_shutdown;
    ept_next = ept_request;
    if (!thr_on) begin
      shdn_next = 1'b0;
      ept_next = 1'b0;
    end else begin
      if (temp9 >= thr + hys) begin
        shdn_next = 1'b1; // R07
      end else if (temp9 < thr) begin
        shdn_next = 1'b0; // R08
      end
      if (temp9 > thr - rx_regs_pkg::T_EPT_BAND) begin
        ept_next = 1'b1; // R09
      end else if (temp9 < thr - rx_regs_pkg::T_EPT_QUIET) begin
        ept_next = 1'b0; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing; flags follow their condition, no software clear exists
  assign cond = '{ts_b_hot, ts_a_hot, die_shutdown, charge_done, disable_pin, thermal_reg_active};
  assign route.ts_b_hot = en_lo_reg[rx_regs_pkg::EN_TS_B_BIT]; // R01
  assign route.ts_a_hot = en_lo_reg[rx_regs_pkg::EN_TS_A_BIT]; // R02
  assign route.die_hot = en_lo_reg[rx_regs_pkg::EN_DIE_BIT]; // R03
  assign route.charge_done = en_lo_reg[rx_regs_pkg::EN_CHG_BIT]; // R04
  assign route.disable_high = en_lo_reg[rx_regs_pkg::EN_DIS_BIT]; // R05
  assign route.thermal_reg = en_hi_reg[rx_regs_pkg::EN_THERM_BIT]; // R06
  assign masked_next = cond & route; // R18
  assign int_oe_next = |masked_next; // R18

  // output voltage source select
  assign vout_next = vout_ctrl_reg[rx_regs_pkg::VOUT_SEL_BIT] ? // R13
    rx_regs_pkg::vout_decode(vout_ctrl_reg[rx_regs_pkg::VOUT_CODE_MSB:0]) : pin_vout_mv; // R14
  assign vout_ok_next = rx_regs_pkg::vout_code_valid(vout_ctrl_reg[rx_regs_pkg::VOUT_CODE_MSB:0]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      masked_reg <= '0;
      int_oe <= 1'b0;
      die_shutdown <= 1'b0;
      ept_request <= 1'b0;
      ept_code <= rx_regs_pkg::EPT_NONE;
      ts_a_reg <= 8'h00;
      ts_b_reg <= 8'h00;
      vout_target_mv <= rx_regs_pkg::VOUT_5V00;
      vout_code_ok <= 1'b1;
      vout_use_reg <= 1'b0;
    end else begin
      masked_reg <= masked_next;
      int_oe <= int_oe_next;
      die_shutdown <= shdn_next;
      ept_request <= ept_next;
      ept_code <= ept_next ? rx_regs_pkg::EPT_DIE_CODE : rx_regs_pkg::EPT_NONE; // R19
      ts_a_reg <= ts_a_adc;
      ts_b_reg <= ts_b_adc;
      vout_target_mv <= vout_next;
      vout_code_ok <= vout_ok_next;
      vout_use_reg <= vout_ctrl_reg[rx_regs_pkg::VOUT_SEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_upper_read;
    req.rd && req.addr == rx_regs_pkg::ADDR_PERIOD_UPPER;
  endsequence
  sequence s_lower_holds(logic [7:0] v);
    lower_shadow_reg == v;
  endsequence

  property p_ts_b_route;
    @(posedge sys_clk) disable iff (!rst_n) (ts_b_hot && en_lo_reg[7]) |=> int_oe && masked_reg.ts_b_hot;
  endproperty
  a_ts_b_route: assert property (p_ts_b_route) else $error("thermistor b fault not routed"); // R01
  property p_ts_a_route;
    @(posedge sys_clk) disable iff (!rst_n) (ts_a_hot && en_lo_reg[6]) |=> int_oe;
  endproperty
  a_ts_a_route: assert property (p_ts_a_route) else $error("thermistor a fault not routed"); // R02
  property p_die_route;
    @(posedge sys_clk) disable iff (!rst_n) (die_shutdown && !en_lo_reg[5]) |=> !masked_reg.die_hot;
  endproperty
  a_die_route: assert property (p_die_route) else $error("die flag set while disabled"); // R03
  property p_chg_route;
    @(posedge sys_clk) disable iff (!rst_n) (charge_done && en_lo_reg[2]) |=> masked_reg.charge_done;
  endproperty
  a_chg_route: assert property (p_chg_route) else $error("charge flag missing"); // R04
  property p_dis_route;
    @(posedge sys_clk) disable iff (!rst_n) (disable_pin && en_lo_reg[0]) |=> int_oe;
  endproperty
  a_dis_route: assert property (p_dis_route) else $error("disable pin not routed"); // R05
  property p_therm_route;
    @(posedge sys_clk) disable iff (!rst_n) (!thermal_reg_active || !en_hi_reg[4]) |=> !masked_reg.thermal_reg;
  endproperty
  a_therm_route: assert property (p_therm_route) else $error("thermal flag set without cause"); // R06
  property p_shdn_on;
    @(posedge sys_clk) disable iff (!rst_n) (thr_on && temp9 >= thr + hys) |=> die_shutdown;
  endproperty
  a_shdn_on: assert property (p_shdn_on) else $error("no shutdown above limit"); // R07
  property p_shdn_off;
    @(posedge sys_clk) disable iff (!rst_n) (temp9 < thr || !thr_on) |=> !die_shutdown;
  endproperty
  a_shdn_off: assert property (p_shdn_off) else $error("shutdown below threshold"); // R08
  property p_ept_band;
    @(posedge sys_clk) disable iff (!rst_n) (thr_on && temp9 > thr - 9'h00a && temp9 < thr) |=> ept_request;
  endproperty
  a_ept_band: assert property (p_ept_band) else $error("no packet request in band"); // R09
  property p_ept_quiet;
    @(posedge sys_clk) disable iff (!rst_n) (temp9 < thr - 9'h014) |=> !ept_request;
  endproperty
  a_ept_quiet: assert property (p_ept_quiet) else $error("packet request far below"); // R10
  property p_ept_code;
    @(posedge sys_clk) disable iff (!rst_n) ept_request |-> ept_code == 8'h02;
  endproperty
  a_ept_code: assert property (p_ept_code) else $error("wrong packet code"); // R19
  property p_vout_sel;
    @(posedge sys_clk) disable iff (!rst_n) !vout_ctrl_reg[7] ##1 !vout_ctrl_reg[7] |-> vout_target_mv == $past(pin_vout_mv);
  endproperty
  a_vout_sel: assert property (p_vout_sel) else $error("pin setpoint not used"); // R13
  property p_period_snap;
    @(posedge sys_clk) disable iff (!rst_n) s_upper_read |=> s_lower_holds($past(period_count[7:0]));
  endproperty
  a_period_snap: assert property (p_period_snap) else $error("lower byte not frozen"); // R20

  ////////////////////////////////////////////////////////////////////////////
  // register-sourced setpoints: both ends of the table and the reserved gap

  property p_vout_low;
    @(posedge sys_clk) disable iff (!rst_n) (vout_ctrl_reg == 8'h86) |=> vout_target_mv == rx_regs_pkg::VOUT_4V50;
  endproperty
  a_vout_low: assert property (p_vout_low) else $error("code 6 not 4.50 V"); // R14

  property p_vout_high;
    @(posedge sys_clk) disable iff (!rst_n) (vout_ctrl_reg == 8'h91) |=> vout_target_mv == rx_regs_pkg::VOUT_6V00;
  endproperty
  a_vout_high: assert property (p_vout_high) else $error("code 17 not 6.00 V"); // R14

  property p_vout_resv;
    @(posedge sys_clk) disable iff (!rst_n) (vout_ctrl_reg[4:0] inside {[5'h01:5'h05]}) |=> !vout_code_ok;
  endproperty
  a_vout_resv: assert property (p_vout_resv) else $error("reserved code valid"); // R14

  ////////////////////////////////////////////////////////////////////////////
  // readback: the conversion byte is one cycle old, the upper period nibble reads zero

  property p_ts_a_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.rd && req.addr == rx_regs_pkg::ADDR_TS_A) |-> rdata == $past(ts_a_adc);
  endproperty
  a_ts_a_read: assert property (p_ts_a_read) else $error("thermistor a byte wrong"); // R15

  property p_upper_nibble;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.rd && req.addr == rx_regs_pkg::ADDR_PERIOD_UPPER) |-> rdata[7:4] == 4'h0;
  endproperty
  a_upper_nibble: assert property (p_upper_nibble) else $error("upper period nibble set"); // R17

  ////////////////////////////////////////////////////////////////////////////
  // no condition present, so nothing may hold the interrupt pin low

  property p_int_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      !(ts_a_hot || ts_b_hot || die_shutdown || charge_done || disable_pin || thermal_reg_active) |=> !int_oe;
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("interrupt without cause"); // R18

endmodule

// [tb.sv]
// self-checking bench for the receiver register bank
// assumes the bench bit-bangs the two-wire port and drives every analog word directly
`timescale 1ns/10ps

module tb;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary target address
  logic sys_clk = 0, rst_n = 0, scl = 1, m_sda = 1, ack, sda_oe, int_oe, sd, end_power_packet, vok, vuse;
  logic [5:0] cond = 6'h00;
  logic [7:0] temp = 8'h00, ts_a = 8'h00, ts_b = 8'h00, q1, q2, ecode;
  logic [11:0] per = 12'h000;
  logic [12:0] vmv, pin_mv = 13'h10e1;
  logic [7:0] ea [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02};
  int eb [6] = '{7, 6, 5, 2, 0, 4};
  logic [7:0] tc [13] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h80, 8'h80, 8'he0, 8'he0, 8'h00};
  logic [7:0] tt [13] = '{100, 121, 149, 150, 140, 129, 115, 109, 149, 150, 149, 170, 200};
  logic [12:0] tsd = 13'b0_1010_0001_1000; // bit i is entry i
  logic [12:0] tep = 13'b0_1111_0111_1110;
  int n_fail = 0, checked = 0;
  wire sda_w = m_sda & ~sda_oe; // open-drain wire, released means high

  always #4 sys_clk = ~sys_clk;

  rx_irq_thermal_vout_regs #(.DEV_ADDR(DEV)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe(sda_oe), .int_i(~int_oe), .int_o(), .int_oe(int_oe), .ts_a_hot(cond[1]), .ts_b_hot(cond[0]),
    .thermal_reg_active(cond[5]), .charge_done(cond[3]), .disable_pin(cond[4]),
    .die_temp_c(cond[2] ? 8'hc8 : temp), .ts_a_adc(ts_a), .ts_b_adc(ts_b), .period_count(per),
    .pin_vout_mv(pin_mv), .die_shutdown(sd), .ept_request(end_power_packet), .ept_code(ecode), .vout_target_mv(vmv),
    .vout_code_ok(vok), .vout_use_reg(vuse));

  ////////////////////////////////////////////////////////////////////////////
  // all stimulus moves on the falling edge, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // start and repeated start; scl phases of four cycles keep the sampler happy
  task automatic start;
    m_sda = 1; cyc(2); scl = 1; cyc(4); m_sda = 0; cyc(4); scl = 0; cyc(2);
  endtask

  task automatic stp;
    m_sda = 0; cyc(2); scl = 1; cyc(4); m_sda = 1; cyc(4);
  endtask

  // eight bits msb first then the ack slot; mack is what the bench puts there
  task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] q);
    logic [8:0] s;
    s = {d, mack};
    for (int i = 8; i >= 0; i--) begin
      m_sda = s[i]; cyc(2); scl = 1; cyc(4);
      if (i > 0) q = {q[6:0], sda_w};
      else ack = sda_w;
      scl = 0; cyc(2);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start; xb({DEV, 1'b0}, 1, q); chk(ack, 0); xb(a, 1, q); xb(d, 1, q); chk(ack, 0); stp;
  endtask

  // two-byte burst read: q1 from a, q2 from a+1, nack on the last byte
  task automatic rd(input logic [7:0] a);
    start; xb({DEV, 1'b0}, 1, q1); xb(a, 1, q1);
    start; xb({DEV, 1'b1}, 1, q1); chk(ack, 0); xb(8'hff, 0, q1); xb(8'hff, 1, q2); stp;
  endtask

  function automatic logic [12:0] exp_mv(input int c);
    case (c)
      6: return 13'd4500;
      7, 8: return 13'd4750;
      9, 10: return 13'd5250;
      11, 12: return 13'd5500;
      13, 14: return 13'd5750;
      15, 16, 17: return 13'd6000;
      default: return 13'd5000;
    endcase
  endfunction

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20); rst_n = 1; cyc(2);
    rd(8'h02); chk(q1, 8'hff); chk(q2, 8'hff);
    rd(8'h08); chk(q1, 8'h60);
    rd(8'h33); chk(q1, 8'h00); chk(vuse, 0); chk(vmv, pin_mv);
    $display("reset values done");
    // each source alone: routed, then masked by clearing its own enable bit
    for (int i = 0; i < 6; i++) begin
      cond[i] = 1; cyc(2); chk(int_oe, 1);
      wr(ea[i], ~(8'h01 << eb[i])); chk(int_oe, 0);
      wr(ea[i], 8'hff); chk(int_oe, 1);
      cond[i] = 0; cyc(2); chk(int_oe, 0);
    end
    $display("interrupt routing done");
    for (int i = 0; i < 13; i++) begin
      wr(8'h08, tc[i]); temp = tt[i]; cyc(2);
      chk(sd, tsd[i]);
      chk(end_power_packet, tep[i]);
      chk(ecode, tep[i] ? 8'h02 : 8'hff);
    end
    temp = 8'h00;
    $display("die thermal done");
    for (int c = 0; c < 18; c++) begin
      wr(8'h33, 8'h80 | 8'(c)); chk(vmv, exp_mv(c)); chk(vuse, 1);
      chk(vok, (c == 0) || (c >= 6));
      rd(8'h33); chk(q1, 8'h80 | 8'(c));
    end
    wr(8'h33, 8'h66); rd(8'h33); chk(q1, 8'h06); chk(vuse, 0); chk(vmv, pin_mv);
    $display("output voltage done");
    ts_a = 8'ha5; ts_b = 8'h3c; per = 12'hb7d;
    rd(8'h69); chk(q1, 8'ha5);
    wr(8'h69, 8'h00); rd(8'h69); chk(q1, 8'ha5);
    rd(8'h6b); chk(q1, 8'h3c);
    rd(8'h7e); chk(q1, 8'h0b); chk(q2, 8'h7d);
    per = 12'h123; rd(8'h7e); chk(q1, 8'h01); chk(q2, 8'h23);
    per = 12'h456; rd(8'h7f); chk(q1, 8'h23);
    $display("readback done");
    end_sim;
  end

  // hang guard
  initial begin
    #600000;
    n_fail++;
    $display("BAD %0t timeout", $time);
    end_sim;
  end
endmodule
